/* bench/nand_dev_model.sv */
// Behavioural model of the flash device that the host controller drives.
`timescale 1ns/1ns
`default_nettype none
module nand_dev_model #(
  parameter int BUSY_NS = 120
) (
  // Pins from the host
  input wire logic ce_n,
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic output_strobe_n,
  input wire logic [7:0] io_out,
  // Test control
  input wire logic stuck,
  // Pins back to the host
  output logic [7:0] io_in,
  output logic done_line
);
  logic [7:0] cmd_q[$];
  logic [7:0] addr_q[$];
  logic [7:0] data_q[$];
  logic [11:0] col;
  logic [7:0] dout;
  logic drv;
  logic st_mode;
  int ai;
  event go;
  initial begin
    col = 12'h000;
    dout = 8'h00;
    drv = 1'b0;
    st_mode = 1'b0;
    ai = 0;
    done_line = 1'b1;
  end
  // A released bus shows the inverse of the last byte, so stale data never passes.
  assign io_in = drv ? dout : ~dout;
  always @(posedge we_n) begin
    if (!ce_n && cle) begin
      cmd_q.push_back(io_out);
      ai = 0;
      st_mode = (io_out == 8'h70);
      if (io_out inside {8'h10, 8'h15, 8'h30, 8'h31, 8'h3F, 8'h3A, 8'hFF}) ->go;
    end else if (!ce_n && ale) begin
      addr_q.push_back(io_out);
      if (ai == 0) col[7:0] = io_out;
      if (ai == 1) col[11:8] = io_out[3:0];
      ai++;
    end else if (!ce_n) begin
      data_q.push_back(io_out);
    end
  end
  always @(go) begin
    #20 done_line = 1'b0;
    #(stuck ? BUSY_NS * 20 : BUSY_NS) done_line = 1'b1;
  end
  // Data stays driven through a strobe high phase under 20 ns until a latch, select or write edge.
  // Access time sits just under its limit, so new data never lands on a clock edge.
  always @(negedge output_strobe_n) begin
    #17 dout = st_mode ? {1'b1, done_line, 6'h00} : col[7:0] + 8'h3C;
    drv = 1'b1;
    if (!st_mode) col = col + 12'h001;
  end
  always @(posedge cle or posedge ale or posedge ce_n or negedge we_n) drv = 1'b0;
  // A long strobe high time lets the outputs go, as in normal serial read.
  always @(posedge output_strobe_n) begin
    #20 if (output_strobe_n) drv = 1'b0;
  end
endmodule // nand_dev_model
`default_nettype wire

/* bench/nand_host_tb_top.sv */
// Self-checking testbench of the flash host controller.
`timescale 1ns/1ns
`default_nettype none
module nand_host_tb_top;
  logic clk, rstn, op_valid, op_last, wr_valid, wr_ready, stuck, got_err;
  nand_host_pkg::op_type op;
  logic [11:0] op_col, op_len;
  logic [16:0] op_row;
  logic [7:0] wr_data, rd_data, status_byte, io_out, io_in;
  logic op_ready, op_done, op_error, rd_valid, ce_n, cle, ale, we_n, output_strobe_n, wp_n, io_oe, done_line;
  logic [7:0] rd_q[$];
  int err_count, check_count;
  nand_host #(.RST_TIMEOUT(40), .FETCH_TIMEOUT(40), .PROG_TIMEOUT(40), .CACHE_TIMEOUT(40)) dut_u (
    .clk(clk), .rstn(rstn), .op_valid(op_valid), .op(op), .op_last(op_last), .op_col(op_col),
    .op_row(op_row), .op_len(op_len), .op_ready(op_ready), .op_done(op_done), .op_error(op_error),
    .status_byte(status_byte), .wr_data(wr_data), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .rd_data(rd_data), .rd_valid(rd_valid), .ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n),
    .output_strobe_n(output_strobe_n), .wp_n(wp_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .done_line(done_line));
  nand_dev_model model_u (.ce_n(ce_n), .cle(cle), .ale(ale), .we_n(we_n), .output_strobe_n(output_strobe_n),
    .io_out(io_out), .stuck(stuck), .io_in(io_in), .done_line(done_line));
  always #2 clk = ~clk;
  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    check_count++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      err_count++;
    end
  endtask
  task automatic push(input logic [7:0] d);
    @(negedge clk);
    wr_data = d;
    wr_valid = 1'b1;
    while (wr_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    wr_valid = 1'b0;
  endtask
  task automatic run_op(input nand_host_pkg::op_type o, input logic last, input logic [16:0] row,
                        input logic [11:0] len);
    int n;
    model_u.cmd_q.delete();
    model_u.addr_q.delete();
    model_u.data_q.delete();
    rd_q.delete();
    n = 0;
    @(negedge clk);
    while (op_ready !== 1'b1) @(negedge clk);
    op = o;
    op_last = last;
    op_row = row;
    op_len = len;
    op_valid = 1'b1;
    @(negedge clk);
    op_valid = 1'b0;
    while (op_done !== 1'b1 && n < 4000) begin
      @(negedge clk);
      if (rd_valid === 1'b1) rd_q.push_back(rd_data);
      n++;
    end
    got_err = op_error;
    check("op_done seen", 8'h01, {7'h00, op_done});
  endtask
  task automatic test_reset();
    run_op(nand_host_pkg::OP_RESET, 1'b0, 17'h00000, 12'h000);
    check("reset error", 8'h00, {7'h00, got_err});
    check("reset command", 8'hFF, model_u.cmd_q[0]);
    check("write protect", 8'h01, {7'h00, wp_n});
    check("bus released", 8'h00, {7'h00, io_oe});
    check("chip deselected", 8'h01, {7'h00, ce_n});
    $display("test reset done");
  endtask
  task automatic test_program();
    logic [7:0] adr[5];
    adr = '{8'hBC, 8'h0A, 8'h45, 8'h23, 8'h01};
    op_col = 12'hABC;
    for (int i = 0; i < 4; i++) push(8'hA1 + 8'(i));
    @(negedge clk);
    check("fifo full ready", 8'h00, {7'h00, wr_ready});
    run_op(nand_host_pkg::OP_PROG, 1'b0, 17'h12345, 12'h004);
    check("program error", 8'h00, {7'h00, got_err});
    check("program setup", 8'h80, model_u.cmd_q[0]);
    check("program start", 8'h10, model_u.cmd_q[1]);
    check("status command", 8'h70, model_u.cmd_q[2]);
    for (int i = 0; i < 5; i++) check("address byte", adr[i], model_u.addr_q[i]);
    for (int i = 0; i < 4; i++) check("data byte", 8'hA1 + 8'(i), model_u.data_q[i]);
    check("ready bit", 8'h01, {7'h00, status_byte[6]});
    $display("test program done");
  endtask
  task automatic test_read();
    op_col = 12'h0FE;
    run_op(nand_host_pkg::OP_READ, 1'b0, 17'h00007, 12'h003);
    check("read error", 8'h00, {7'h00, got_err});
    check("read count", 8'h03, 8'(rd_q.size()));
    for (int i = 0; i < 3; i++) check("read byte", 8'(12'h0FE + 12'(i)) + 8'h3C, rd_q[i]);
    $display("test read done");
  endtask
  task automatic test_partial();
    op_col = 12'h000;
    for (int i = 0; i < 3; i++) begin
      run_op(nand_host_pkg::OP_PROG, 1'b0, 17'h12345, 12'h000);
      check("partial error", 8'h00, {7'h00, got_err});
    end
    run_op(nand_host_pkg::OP_PROG, 1'b0, 17'h12345, 12'h000);
    check("fifth refused", 8'h01, {7'h00, got_err});
    check("refused pins", 8'h00, 8'(model_u.cmd_q.size()));
    $display("test partial done");
  endtask
  task automatic test_cache();
    push(8'h5A);
    run_op(nand_host_pkg::OP_CACHE_PROG, 1'b0, 17'h00040, 12'h001);
    check("cache error", 8'h00, {7'h00, got_err});
    check("cache start", 8'h15, model_u.cmd_q[1]);
    run_op(nand_host_pkg::OP_READ, 1'b0, 17'h00040, 12'h001);
    check("open refused", 8'h01, {7'h00, got_err});
    push(8'hC3);
    run_op(nand_host_pkg::OP_CACHE_PROG, 1'b1, 17'h00041, 12'h001);
    check("final error", 8'h00, {7'h00, got_err});
    check("final start", 8'h10, model_u.cmd_q[1]);
    check("final data", 8'hC3, model_u.data_q[0]);
    run_op(nand_host_pkg::OP_CACHE_PROG, 1'b0, 17'h00042, 12'h000);
    run_op(nand_host_pkg::OP_RESET, 1'b0, 17'h00000, 12'h000);
    check("reset closes cache", 8'h00, {7'h00, got_err});
    run_op(nand_host_pkg::OP_READ, 1'b0, 17'h00042, 12'h000);
    check("read after reset", 8'h00, {7'h00, got_err});
    $display("test cache done");
  endtask
  task automatic test_timeout();
    int n;
    n = 0;
    stuck = 1'b1;
    run_op(nand_host_pkg::OP_RESET, 1'b0, 17'h00000, 12'h000);
    check("busy timeout", 8'h01, {7'h00, got_err});
    stuck = 1'b0;
    run_op(nand_host_pkg::OP_STATUS, 1'b0, 17'h00000, 12'h000);
    check("status poll error", 8'h00, {7'h00, got_err});
    check("status poll command", 8'h70, model_u.cmd_q[0]);
    check("status after poll", 8'hC0, status_byte);
    while (done_line !== 1'b1 && n < 1000) begin
      @(negedge clk);
      n++;
    end
    $display("test timeout done");
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    op_valid = 1'b0;
    op = nand_host_pkg::OP_RESET;
    op_last = 1'b0;
    op_col = 12'h000;
    op_row = 17'h00000;
    op_len = 12'h000;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    stuck = 1'b0;
    err_count = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rstn = 1'b1;
    test_reset();
    test_program();
    test_read();
    test_partial();
    test_cache();
    test_timeout();
    complete_run();
  end
  // Every operation ends well below this span, so reaching it means a hang.
  initial begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule // nand_host_tb_top
`default_nettype wire

/* inc/nand_host_pkg.sv */
// Constants, commands and types of the NAND flash host controller.
//
// Overview of operation
// RQ1: Reset busy ends within 5/5/10/500 us.
// RQ2: Cache program 11h busy at most 10 us.
// RQ3: Cache program 15h busy at most 700 us.
// RQ4: At most 4 partial programs per page; the code counts only the most recent page.
// RQ5: Array fetch to page register within 25 us.
// RQ6: Cache read 31h/3Fh busy at most 25 us.
// RQ7: Page copy 3Ah busy at most 30 us.
// RQ8: Long strobe high time turns outputs off.
// RQ9: Short strobe high time keeps data driven.
// RQ10: Latch, chip select or write edge ends output.
// RQ11: Close cached programming with 80h then 10h.
// RQ12: After 15h ending, poll status bit 6.
// RQ13: After 15h ending completes, issue reset FFh.
// RQ14: Last cached page programs after previous page.
// RQ15: Last page busy bounded by program time maximum; the code waits up to twice that (2 * PROG_TIMEOUT).
// RQ16: Command latch held high across write strobe rise.
// RQ17: Done line low while busy, high when finished.
// RQ18: Wait for ready before issuing busy-refused commands.
package nand_host_pkg;

  // ------------------------------------------------------------
  // Clock and strobe timing
  // ------------------------------------------------------------
  localparam int CLK_NS = 4;
  localparam int T_CS_NS = 20;
  localparam int T_SETUP_NS = 12;
  localparam int T_WP_NS = 12;
  localparam int T_HOLD_NS = 5;
  localparam int T_WB_NS = 100;
  localparam int T_RR_NS = 20;
  localparam int T_REA_NS = 20;
  localparam int T_REH_NS = 10;
  localparam int T_RC_NS = 25;
  localparam int T_WHR_NS = 60;
  localparam int SYNC_STAGES = 2;

  localparam int CS_CYC = (T_CS_NS + CLK_NS - 1) / CLK_NS;
  localparam int SETUP_CYC = (T_SETUP_NS + CLK_NS - 1) / CLK_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYC = (T_HOLD_NS + CLK_NS - 1) / CLK_NS;
  localparam int WR_CYC = SETUP_CYC + WP_CYC + HOLD_CYC;
  localparam int WB_CYC = (T_WB_NS + CLK_NS - 1) / CLK_NS + SYNC_STAGES;
  localparam int RR_CYC = (T_RR_NS + CLK_NS - 1) / CLK_NS;
  // Output register plus synchroniser sit between the strobe and the sample.
  localparam int RD_LOW_CYC = (T_REA_NS + CLK_NS - 1) / CLK_NS + 1 + SYNC_STAGES;
  localparam int REH_CYC = (T_REH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RC_CYC = (T_RC_NS + CLK_NS - 1) / CLK_NS;
  localparam int RD_HIGH_CYC = (RC_CYC - RD_LOW_CYC > REH_CYC) ? RC_CYC - RD_LOW_CYC : REH_CYC;
  localparam int RD_CYC = RD_LOW_CYC + RD_HIGH_CYC;
  localparam int WHR_CYC = (T_WHR_NS + CLK_NS - 1) / CLK_NS;

  // ------------------------------------------------------------
  // Busy limits, used as time-outs
  // ------------------------------------------------------------
  localparam int T_RST_MAX_US = 500;
  localparam int T_FETCH_MAX_US = 25;
  localparam int T_PROG_MAX_US = 700;
  localparam int T_CACHE_WRITE_MAX_US = 700;
  localparam int RST_TIMEOUT_CYC = T_RST_MAX_US * 1000 / CLK_NS;
  localparam int FETCH_TIMEOUT_CYC = T_FETCH_MAX_US * 1000 / CLK_NS;
  localparam int PROG_TIMEOUT_CYC = T_PROG_MAX_US * 1000 / CLK_NS;
  localparam int CACHE_TIMEOUT_CYC = T_CACHE_WRITE_MAX_US * 1000 / CLK_NS;

  // ------------------------------------------------------------
  // Command codes, status bits and geometry
  // ------------------------------------------------------------
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_START = 8'h30;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h80;
  localparam logic [7:0] CMD_PROG_START = 8'h10;
  localparam logic [7:0] CMD_CACHE_START = 8'h15;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_RESET = 8'hFF;
  localparam int STATUS_READY_BIT = 6;
  localparam int STATUS_FAIL_BIT = 0;
  localparam logic [2:0] PARTIAL_MAX = 3'h4;
  localparam logic [11:0] ADDR_CYCLES = 12'h005;
  localparam int FIFO_DEPTH = 4;
  localparam int CNT_W = 20;

  typedef enum logic [2:0] {
    OP_RESET,
    OP_READ,
    OP_PROG,
    OP_CACHE_PROG,
    OP_STATUS
  } op_type;

endpackage

/* rtl/fifo_buf.sv */
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/1ns
`default_nettype none
module fifo_buf #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Filling side
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW-1:0] wptr;
  logic [PW-1:0] rptr;
  logic [CW-1:0] count;

  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  wire [CW-1:0] next_count = CW'(count + CW'(push) - CW'(pop));
  wire [PW-1:0] wptr_inc = (wptr == PW'(DEPTH - 1)) ? '0 : PW'(wptr + 1'b1);
  wire [PW-1:0] rptr_inc = (rptr == PW'(DEPTH - 1)) ? '0 : PW'(rptr + 1'b1);

  assign out_data = mem[rptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wptr <= '0;
      rptr <= '0;
      count <= '0;
      in_ready <= 1'b0;
      out_valid <= 1'b0;
    end else begin
      wptr <= push ? wptr_inc : wptr;
      rptr <= pop ? rptr_inc : rptr;
      count <= next_count;
      in_ready <= next_count != CW'(DEPTH);
      out_valid <= next_count != '0;
    end
  end

endmodule // fifo_buf
`default_nettype wire

/* rtl/nand_host.sv */
// Host controller that drives a NAND flash over its command, address and data pins.
`timescale 1ns/1ns
`default_nettype none
module nand_host #(
  parameter int RST_TIMEOUT = nand_host_pkg::RST_TIMEOUT_CYC,
  parameter int FETCH_TIMEOUT = nand_host_pkg::FETCH_TIMEOUT_CYC,
  parameter int PROG_TIMEOUT = nand_host_pkg::PROG_TIMEOUT_CYC,
  parameter int CACHE_TIMEOUT = nand_host_pkg::CACHE_TIMEOUT_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Operation request
  input wire logic op_valid,
  input wire nand_host_pkg::op_type op,
  input wire logic op_last,
  input wire logic [11:0] op_col,
  input wire logic [16:0] op_row,
  input wire logic [11:0] op_len,
  output logic op_ready,
  output logic op_done,
  output logic op_error,
  output logic [7:0] status_byte,
  // Program data
  input wire logic [7:0] wr_data,
  input wire logic wr_valid,
  output logic wr_ready,
  // Read data
  output logic [7:0] rd_data,
  output logic rd_valid,
  // Flash pins
  output logic ce_n,
  output logic cle,
  output logic ale,
  output logic we_n,
  output logic output_strobe_n,
  output logic wp_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic done_line
);

  // ------------------------------------------------------------
  // State and registers
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_IDLE, ST_CE_SETUP, ST_CMD1, ST_ADDR, ST_DIN, ST_CMD2, ST_WAIT_WB, ST_WAIT_RDY,
    ST_GAP, ST_STAT_CMD, ST_STAT_GAP, ST_STAT_RD, ST_DOUT, ST_DONE
  } state_type;

  localparam int CW = nand_host_pkg::CNT_W;

  state_type state;
  state_type next_state;
  logic [CW-1:0] cnt;
  logic [11:0] idx;
  nand_host_pkg::op_type cur_op;
  logic cur_last;
  logic [11:0] cur_col;
  logic [16:0] cur_row;
  logic [11:0] cur_len;
  logic err;
  logic cache_open;
  logic [16:0] last_row;
  logic [2:0] prog_count;
  logic [7:0] io_meta;
  logic [7:0] io_s;
  logic rdy_meta;
  logic rdy_s;
  logic fifo_valid;
  logic [7:0] fifo_data;
  logic fifo_pop;

  // Write data is staged so the host can stall the source while the page register fills.
  fifo_buf #(.WIDTH(8), .DEPTH(nand_host_pkg::FIFO_DEPTH)) wbuf (
    .clk(clk),
    .rstn(rstn),
    .in_valid(wr_valid),
    .in_data(wr_data),
    .in_ready(wr_ready),
    .out_valid(fifo_valid),
    .out_data(fifo_data),
    .out_ready(fifo_pop)
  );

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  wire take = state == ST_IDLE && op_valid;
  wire is_prog_op = op == nand_host_pkg::OP_PROG || op == nand_host_pkg::OP_CACHE_PROG;
  wire same_row = op_row == last_row;
  wire over_partial = is_prog_op && same_row && prog_count == nand_host_pkg::PARTIAL_MAX; // RQ4
  wire open_block = cache_open && op != nand_host_pkg::OP_CACHE_PROG && op != nand_host_pkg::OP_RESET; // RQ11
  wire refuse = over_partial || open_block;
  wire wr_state = state == ST_CMD1 || state == ST_ADDR || state == ST_DIN || state == ST_CMD2
                  || state == ST_STAT_CMD;
  wire rd_state = state == ST_STAT_RD || state == ST_DOUT;
  wire din_stall = state == ST_DIN && cnt == '0 && !fifo_valid;
  wire wr_low = cnt >= CW'(nand_host_pkg::SETUP_CYC)
                && cnt < CW'(nand_host_pkg::SETUP_CYC + nand_host_pkg::WP_CYC);
  wire wr_end = cnt == CW'(nand_host_pkg::WR_CYC - 1);
  wire rd_low = cnt < CW'(nand_host_pkg::RD_LOW_CYC);
  wire rd_sample = cnt == CW'(nand_host_pkg::RD_LOW_CYC - 1);
  // A short strobe high phase of REH_CYC cycles keeps the flash driving data between bytes.
  wire rd_end = cnt == CW'(nand_host_pkg::RD_CYC - 1); // RQ9
  assign fifo_pop = state == ST_DIN && wr_end;
  wire addr_last = idx == 12'(nand_host_pkg::ADDR_CYCLES - 12'h001);
  wire len_last = idx == 12'(cur_len - 12'h001);
  wire cache_15 = cur_op == nand_host_pkg::OP_CACHE_PROG && !cur_last;

  // Busy limit that bounds the wait for the done line.
  wire [CW-1:0] limit = (cur_op == nand_host_pkg::OP_RESET) ? CW'(RST_TIMEOUT) : // RQ1
                        (cur_op == nand_host_pkg::OP_READ) ? CW'(FETCH_TIMEOUT) : // RQ5
                        cache_15 ? CW'(CACHE_TIMEOUT) : // RQ3
                        (cur_op == nand_host_pkg::OP_CACHE_PROG) ? CW'(2 * PROG_TIMEOUT) : // RQ14 RQ15
                        CW'(PROG_TIMEOUT);
  wire timeout = cnt >= limit;

  wire [7:0] first_cmd = (cur_op == nand_host_pkg::OP_RESET) ? nand_host_pkg::CMD_RESET :
                         (cur_op == nand_host_pkg::OP_READ) ? nand_host_pkg::CMD_READ_SETUP :
                         (cur_op == nand_host_pkg::OP_STATUS) ? nand_host_pkg::CMD_STATUS :
                         nand_host_pkg::CMD_PROG_SETUP;
  wire [7:0] second_cmd = (cur_op == nand_host_pkg::OP_READ) ? nand_host_pkg::CMD_READ_START :
                          cache_15 ? nand_host_pkg::CMD_CACHE_START :
                          nand_host_pkg::CMD_PROG_START; // RQ11
  wire [7:0] addr_byte = (idx == 12'h000) ? cur_col[7:0] :
                         (idx == 12'h001) ? {4'h0, cur_col[11:8]} :
                         (idx == 12'h002) ? cur_row[7:0] :
                         (idx == 12'h003) ? cur_row[15:8] : {7'h00, cur_row[16]};
  wire [7:0] cur_byte = (state == ST_CMD1) ? first_cmd :
                        (state == ST_ADDR) ? addr_byte :
                        (state == ST_DIN) ? fifo_data :
                        (state == ST_CMD2) ? second_cmd : nand_host_pkg::CMD_STATUS;

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_state = state;
    unique case (state)
      ST_IDLE: if (take) next_state = refuse ? ST_DONE : ST_CE_SETUP;
      ST_CE_SETUP: if (cnt == CW'(nand_host_pkg::CS_CYC - 1)) next_state = ST_CMD1;
      ST_CMD1: if (wr_end) begin
        next_state = (cur_op == nand_host_pkg::OP_RESET) ? ST_WAIT_WB :
                     (cur_op == nand_host_pkg::OP_STATUS) ? ST_STAT_GAP : ST_ADDR;
      end
      ST_ADDR: if (wr_end && addr_last) begin
        next_state = (cur_op == nand_host_pkg::OP_READ || cur_len == 12'h000) ? ST_CMD2 : ST_DIN;
      end
      ST_DIN: if (wr_end && len_last) next_state = ST_CMD2;
      ST_CMD2: if (wr_end) next_state = ST_WAIT_WB;
      ST_WAIT_WB: if (cnt == CW'(nand_host_pkg::WB_CYC - 1)) next_state = ST_WAIT_RDY;
      // No command leaves the host until the done line has come back high or the busy limit has run out.
      ST_WAIT_RDY: if (rdy_s) next_state = ST_GAP; else if (timeout) next_state = ST_DONE; // RQ17 RQ18
      ST_GAP: if (cnt == CW'(nand_host_pkg::RR_CYC - 1)) begin
        next_state = (cur_op == nand_host_pkg::OP_RESET) ? ST_DONE :
                     (cur_op != nand_host_pkg::OP_READ) ? ST_STAT_CMD :
                     (cur_len == 12'h000) ? ST_DONE : ST_DOUT;
      end
      ST_STAT_CMD: if (wr_end) next_state = ST_STAT_GAP;
      ST_STAT_GAP: if (cnt == CW'(nand_host_pkg::WHR_CYC - 1)) next_state = ST_STAT_RD;
      // Status is re-read until the ready bit shows the previous page finished.
      ST_STAT_RD: if (rd_end && status_byte[nand_host_pkg::STATUS_READY_BIT]) next_state = ST_DONE; // RQ12
      ST_DOUT: if (rd_end && len_last) next_state = ST_DONE;
      ST_DONE: next_state = ST_IDLE;
    endcase
  end

  wire moving = state != next_state;
  wire byte_end = (wr_state && wr_end) || (rd_state && rd_end);
  wire [CW-1:0] next_cnt = (moving || din_stall || byte_end || state == ST_IDLE) ? '0 : CW'(cnt + 1'b1);
  wire [11:0] next_idx = moving ? 12'h000 : byte_end ? 12'(idx + 12'h001) : idx;
  wire prog_fail = cur_op != nand_host_pkg::OP_READ && cur_op != nand_host_pkg::OP_STATUS
                   && state == ST_STAT_RD && rd_sample && io_s[nand_host_pkg::STATUS_FAIL_BIT];
  wire next_err = take ? refuse : (err || prog_fail || (state == ST_WAIT_RDY && !rdy_s && timeout));

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state <= ST_IDLE;
      cnt <= '0;
      idx <= 12'h000;
      err <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      idx <= next_idx;
      err <= next_err;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cur_op <= nand_host_pkg::OP_RESET;
      cur_last <= 1'b0;
      cur_col <= 12'h000;
      cur_row <= 17'h00000;
      cur_len <= 12'h000;
    end else if (take) begin
      cur_op <= op;
      cur_last <= op_last;
      cur_col <= op_col;
      cur_row <= op_row;
      cur_len <= op_len;
    end
  end

  // ------------------------------------------------------------
  // Cache sequence and partial program tracking
  // ------------------------------------------------------------
  // Only the most recent page is tracked, so moving away and back restarts its count.
  wire [2:0] next_prog_count = same_row ? 3'(prog_count + 3'h1) : 3'h1; // RQ4
  wire cmd2_done = state == ST_CMD2 && wr_end && cur_op == nand_host_pkg::OP_CACHE_PROG;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cache_open <= 1'b0;
      last_row <= 17'h00000;
      prog_count <= 3'h0;
    end else begin
      if (take && !refuse && op == nand_host_pkg::OP_RESET) begin
        cache_open <= 1'b0; // RQ13
      end else if (cmd2_done) begin
        cache_open <= !cur_last; // RQ11
      end
      if (take && !refuse && is_prog_op) begin
        last_row <= op_row;
        prog_count <= next_prog_count;
      end
    end
  end

  // ------------------------------------------------------------
  // Pin inputs and registered outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      io_meta <= 8'h00;
      io_s <= 8'h00;
      rdy_meta <= 1'b0;
      rdy_s <= 1'b0;
    end else begin
      io_meta <= io_in;
      io_s <= io_meta;
      rdy_meta <= done_line;
      rdy_s <= rdy_meta;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ce_n <= 1'b1;
      cle <= 1'b0;
      ale <= 1'b0;
      we_n <= 1'b1;
      output_strobe_n <= 1'b1;
      wp_n <= 1'b0;
      io_out <= 8'h00;
      io_oe <= 1'b0;
    end else begin
      ce_n <= state == ST_IDLE || state == ST_DONE;
      // Command latch stays up through the hold phase after the write strobe rises.
      cle <= state == ST_CMD1 || state == ST_CMD2 || state == ST_STAT_CMD; // RQ16
      ale <= state == ST_ADDR;
      we_n <= !(wr_state && wr_low && !din_stall); // RQ16
      output_strobe_n <= !(rd_state && rd_low);
      wp_n <= 1'b1;
      io_out <= cur_byte;
      io_oe <= wr_state;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      op_ready <= 1'b0;
      op_done <= 1'b0;
      op_error <= 1'b0;
      status_byte <= 8'h00;
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
    end else begin
      op_ready <= next_state == ST_IDLE;
      op_done <= state == ST_DONE;
      op_error <= state == ST_DONE && err;
      status_byte <= (state == ST_STAT_RD && rd_sample) ? io_s : status_byte;
      rd_data <= (state == ST_DOUT && rd_sample) ? io_s : rd_data;
      rd_valid <= state == ST_DOUT && rd_sample;
    end
  end

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  sequence s_refused_read;
    take && cache_open && op == nand_host_pkg::OP_READ;
  endsequence
  sequence s_ends_in_error;
    state == ST_DONE ##1 op_error;
  endsequence
  sequence s_wait_expired;
    state == ST_WAIT_RDY && !rdy_s && timeout;
  endsequence

  we_pulse_width_a: assert property ($fell(we_n) |-> !we_n ##1 !we_n ##1 !we_n ##1 we_n) // RQ16
    else $error("write strobe low time is not three cycles");
  cle_across_rise_a: assert property (cle && !we_n |=> cle) // RQ16
    else $error("command latch dropped before write strobe rose");
  quiet_while_busy_a: assert property (state == ST_WAIT_RDY |-> we_n && output_strobe_n) // RQ18
    else $error("strobe toggled while waiting for ready");
  partial_cap_a: assert property (prog_count <= nand_host_pkg::PARTIAL_MAX) // RQ4
    else $error("partial program count passed its limit");
  cache_close_a: assert property (cmd2_done && cur_last |=> !cache_open && io_out == 8'h10) // RQ11
    else $error("cached programming not closed with 10h");
  open_refuse_a: assert property (s_refused_read |=> s_ends_in_error) // RQ11
    else $error("read accepted while cached programming open");
  status_poll_a: assert property (state == ST_STAT_RD && rd_end && !status_byte[6] |=> state == ST_STAT_RD) // RQ12
    else $error("status polling stopped before ready bit");
  reset_clears_a: assert property (take && !refuse && op == nand_host_pkg::OP_RESET |=> !cache_open) // RQ13
    else $error("reset left cached programming open");
  busy_timeout_a: assert property (s_wait_expired |=> s_ends_in_error) // RQ1
    else $error("busy time-out did not end in an error");

endmodule // nand_host
`default_nettype wire
